// file: rtl/sbsc_defs.svh
`ifndef SBSC_DEFS_SVH
`define SBSC_DEFS_SVH

// ***********************************************
// organisation defaults
// ***********************************************
`define SBSC_ADDR_W 19
`define SBSC_LANES 4
`define SBSC_LANE_W 9

// ***********************************************
// burst counter
// ***********************************************
`define SBSC_BURST_LSB 0
`define SBSC_BURST_W 2
`define SBSC_CNT_RESET 2'h0

// ***********************************************
// wake-up timing after sleep
// ***********************************************
`define SBSC_WAKE_CYCLES 2
`define SBSC_WAKE_CNT_W 2

`endif

// file: rtl/sbsc_pkg.sv
package sbsc_pkg;

  typedef enum logic [2:0] {
    OP_IDLE,
    OP_DESEL,
    OP_BEGIN,
    OP_CONT,
    OP_SUSP
  } sbsc_op_e;

  typedef enum logic [1:0] {
    ST_SLEEP,
    ST_WAKE,
    ST_RUN
  } sbsc_state_e;

  typedef logic [1:0] sbsc_burst_t;

endpackage : sbsc_pkg

// file: rtl/sbsc_array.sv
`timescale 1ns/1ps
`include "sbsc_defs.svh"

module sbsc_array #(
  parameter int ADDR_W = `SBSC_ADDR_W,
  parameter int LANES = `SBSC_LANES,
  parameter int LANE_W = `SBSC_LANE_W
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic rdEn,
  input wire logic [LANES-1:0] wrLanes,
  input wire logic [LANES*LANE_W-1:0] wrData,
  output logic [LANES*LANE_W-1:0] rdData
);

  // ***********************************************
  // storage
  // ***********************************************
  // no reset on the cells: contents survive sleep and reset alike
  logic [LANES*LANE_W-1:0] mem [0:(1<<ADDR_W)-1];

  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < LANES; i++) begin
      if (wrLanes[i]) begin
        mem[addr][i*LANE_W +: LANE_W] <= wrData[i*LANE_W +: LANE_W];
      end
    end
  end

  // ***********************************************
  // first read stage: data-out register
  // ***********************************************
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rdData <= '0;
    end else if (rdEn) begin
      rdData <= mem[addr];
    end
  end

endmodule : sbsc_array

// file: rtl/sbsc_access_ctrl.sv
// Operation
// - sleep high forces power-down and every data pin off, regardless of other inputs.
// - read data drives pins only with output enable low; else pins off.
// - primary high with controller strobe low, or bad second/third select, deselects.
// - all selects active, processor strobe low: load address, begin burst read.
// - controller strobe start loads address; write if decode low, else read.
// - no new burst and step low: advance burst address, read or write.
// - no new burst and step high: hold address and repeat access.
// - continue and suspend cycles follow each cycle's write decode.
// - write decode low means write, high means read, except processor-strobe starts, which always read.
// - global write low writes all lanes; global and gate high reads.
// - gate low writes lanes whose enable is low; four or two lanes.
// - synchronous inputs sampled on rising edge only; sleep, output enable async; here both are also sampled on the rising edge.
// - two-bit counter seeded from low address, linear or interleaved wrap.
// - sleep-exit edge plus two cycles of wake-up after sleep falls before accesses work.
// - read data passes data-out register then output buffer, two edges.
// - lane enables ignored on processor-strobe start, sampled on controller start.
`timescale 1ns/1ps
`include "sbsc_defs.svh"

module sbsc_access_ctrl
  import sbsc_pkg::*;
#(
  parameter int ADDR_W = `SBSC_ADDR_W,
  parameter int LANES = `SBSC_LANES,
  parameter int LANE_W = `SBSC_LANE_W
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic sleepRequest,
  input wire logic outputEnableN,
  input wire logic chipSelectPrimaryN,
  input wire logic chipSelectSecondary,
  input wire logic chipSelectTertiaryN,
  input wire logic processorAddrStrobeN,
  input wire logic controllerAddrStrobeN,
  input wire logic burstStepN,
  input wire logic globalWriteN,
  input wire logic byteWriteGateN,
  input wire logic [LANES-1:0] laneWriteN,
  input wire logic burstOrderSelectN,
  input wire logic [ADDR_W-1:0] addrIn,
  input wire logic [LANES*LANE_W-1:0] dqIn,
  output logic [LANES*LANE_W-1:0] dqOut,
  output logic dqOeN,
  output sbsc_pkg::sbsc_state_e powerState,
  output sbsc_pkg::sbsc_op_e lastOp
);
  import sbsc_pkg::*;

  // ***********************************************
  // elaboration checks
  // ***********************************************
  if (LANES != 4 && LANES != 2) begin : g_bad_lanes
    $error("LANES must be 4 or 2");
  end
  if (ADDR_W < `SBSC_BURST_W + 1) begin : g_bad_addr
    $error("ADDR_W too small for burst counter");
  end

  // ***********************************************
  // helpers
  // ***********************************************
  // active-high lane write mask; all zero means read
  function automatic logic [LANES-1:0] laneDecode(input logic gwN, input logic bwN,
                                                  input logic [LANES-1:0] weN);
    if (!gwN) begin
      laneDecode = '1;
    end else if (bwN) begin
      laneDecode = '0;
    end else begin
      laneDecode = ~weN;
    end
  endfunction : laneDecode

  // low address bits for a given seed and count
  function automatic sbsc_burst_t burstLow(input sbsc_burst_t seed, input sbsc_burst_t cnt,
                                           input logic interleave);
    burstLow = interleave ? (seed ^ cnt) : sbsc_burst_t'(seed + cnt);
  endfunction : burstLow

  // ***********************************************
  // power state
  // ***********************************************
  sbsc_state_e state;
  logic [`SBSC_WAKE_CNT_W-1:0] wakeCnt;
  logic awake;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state <= ST_RUN;
      wakeCnt <= '0;
    end else begin
      case (state)
        ST_SLEEP: begin
          if (!sleepRequest) begin
            state <= ST_WAKE;
            wakeCnt <= `SBSC_WAKE_CNT_W'(`SBSC_WAKE_CYCLES - 1);
          end
        end
        ST_WAKE: begin
          if (sleepRequest) begin
            state <= ST_SLEEP;
          end else if (wakeCnt == '0) begin
            state <= ST_RUN;
          end else begin
            wakeCnt <= wakeCnt - 1'b1;
          end
        end
        ST_RUN: begin
          if (sleepRequest) begin
            state <= ST_SLEEP;
          end
        end
        default: begin
          state <= ST_SLEEP;
        end
      endcase
    end
  end

  // sleep acts on the same edge it is seen; counter state is preserved
  assign awake = (state == ST_RUN) && !sleepRequest;

  // ***********************************************
  // cycle decode
  // ***********************************************
  logic selAll;
  logic badSel;
  logic [LANES-1:0] wrDecode;
  sbsc_op_e opNow;
  logic [LANES-1:0] wrLanes;
  logic burstActive;

  assign selAll = !chipSelectPrimaryN && chipSelectSecondary && !chipSelectTertiaryN;
  assign badSel = !chipSelectSecondary || chipSelectTertiaryN;
  assign wrDecode = laneDecode(globalWriteN, byteWriteGateN, laneWriteN);

  // all of these are sampled values at the rising edge only
  always_comb begin
    opNow = OP_IDLE;
    wrLanes = '0;
    if (!awake) begin
      opNow = OP_IDLE;
    end else if (chipSelectPrimaryN && !controllerAddrStrobeN) begin
      opNow = OP_DESEL;
    end else if (!chipSelectPrimaryN && badSel &&
                 (!processorAddrStrobeN || !controllerAddrStrobeN)) begin
      opNow = OP_DESEL;
    end else if (selAll && !processorAddrStrobeN) begin
      opNow = OP_BEGIN;
    end else if (selAll && !controllerAddrStrobeN) begin
      opNow = OP_BEGIN;
      wrLanes = wrDecode;
    end else if (burstActive) begin
      // primary high blocks the processor strobe, so it lands here
      opNow = burstStepN ? OP_SUSP : OP_CONT;
      wrLanes = wrDecode;
    end
  end

  // ***********************************************
  // burst address register
  // ***********************************************
  logic [ADDR_W-1:0] baseAddr;
  sbsc_burst_t burstCnt;
  logic [ADDR_W-1:0] next_baseAddr;
  sbsc_burst_t next_burstCnt;
  logic [ADDR_W-1:0] accessAddr;
  logic interleave;

  assign interleave = burstOrderSelectN;

  always_comb begin
    next_baseAddr = baseAddr;
    next_burstCnt = burstCnt;
    case (opNow)
      OP_BEGIN: begin
        next_baseAddr = addrIn;
        next_burstCnt = `SBSC_CNT_RESET;
      end
      OP_CONT: begin
        next_burstCnt = sbsc_burst_t'(burstCnt + 1'b1);
      end
      default: begin
        next_burstCnt = burstCnt;
      end
    endcase
  end

  assign accessAddr = {next_baseAddr[ADDR_W-1:`SBSC_BURST_W],
                       burstLow(next_baseAddr[`SBSC_BURST_W-1:`SBSC_BURST_LSB],
                                next_burstCnt, interleave)};

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      baseAddr <= '0;
      burstCnt <= `SBSC_CNT_RESET;
    end else begin
      baseAddr <= next_baseAddr;
      burstCnt <= next_burstCnt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      burstActive <= 1'b0;
    end else if (opNow == OP_DESEL) begin
      burstActive <= 1'b0;
    end else if (opNow == OP_BEGIN) begin
      burstActive <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      lastOp <= OP_IDLE;
      powerState <= ST_RUN;
    end else begin
      lastOp <= opNow;
      powerState <= state;
    end
  end

  // ***********************************************
  // array and read pipeline
  // ***********************************************
  logic rdEn;
  logic rdStage1;
  logic [LANES*LANE_W-1:0] arrayData;

  assign rdEn = (opNow == OP_BEGIN || opNow == OP_CONT || opNow == OP_SUSP) &&
                (wrLanes == '0);

  sbsc_array #(
    .ADDR_W(ADDR_W),
    .LANES(LANES),
    .LANE_W(LANE_W)
  ) u_array (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .addr(accessAddr),
    .rdEn(rdEn),
    .wrLanes(wrLanes),
    .wrData(dqIn),
    .rdData(arrayData)
  );

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rdStage1 <= 1'b0;
    end else begin
      rdStage1 <= rdEn;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      dqOut <= '0;
    end else if (rdStage1) begin
      dqOut <= arrayData;
    end
  end

  // output buffer is registered, so the async gates act one edge later
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      dqOeN <= 1'b1;
    end else begin
      dqOeN <= !(rdStage1 && !outputEnableN && !sleepRequest);
    end
  end

  // ***********************************************
  // checks
  // ***********************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_read_issue;
    rdEn ##1 (!outputEnableN && !sleepRequest);
  endsequence

  sequence s_sleep_exit;
    $fell(sleepRequest) && state == ST_SLEEP;
  endsequence

  AST_SLEEP_OFF: assert property (sleepRequest |=> dqOeN && !rdEn)
    else $error("pins driven or access during sleep");
  AST_OE_OFF: assert property (outputEnableN |=> dqOeN)
    else $error("pins driven with output enable high");
  AST_WRITE_OFF: assert property ((wrLanes != '0) |=> ##1 dqOeN)
    else $error("pins driven after a write cycle");
  AST_DESEL: assert property ((opNow == OP_DESEL) |-> !rdEn && wrLanes == '0 ##1 !burstActive)
    else $error("deselect performed an access");
  AST_PROC_START: assert property (awake && selAll && !processorAddrStrobeN |->
    rdEn && wrLanes == '0 ##1 baseAddr == $past(addrIn) && burstCnt == 2'h0)
    else $error("processor strobe start not a read at new address");
  AST_CTRL_START: assert property (awake && selAll && processorAddrStrobeN &&
    !controllerAddrStrobeN |-> wrLanes == wrDecode ##1 baseAddr == $past(addrIn))
    else $error("controller strobe start wrong");
  AST_STEP: assert property (opNow == OP_CONT |=>
    burstCnt == sbsc_burst_t'($past(burstCnt) + 2'h1))
    else $error("burst did not advance");
  AST_SUSPEND: assert property (opNow == OP_SUSP |=> $stable(burstCnt) && $stable(baseAddr))
    else $error("suspend moved the address");
  AST_CONT_WRITE: assert property ((opNow == OP_SUSP || opNow == OP_CONT) && !globalWriteN
    |-> wrLanes == '1 && !rdEn)
    else $error("global write not applied to all lanes");
  AST_WAKE: assert property (s_sleep_exit |-> !awake ##1 !awake)
    else $error("access during wake-up");
  AST_PIPE: assert property (s_read_issue |=> !dqOeN && dqOut == $past(arrayData))
    else $error("read pipeline not two stages");

endmodule : sbsc_access_ctrl

// file: bench/sbsc_master_model.sv
`timescale 1ns/1ps
module sbsc_master_model (
  input wire logic clk_sys,
  output logic sleepRequest,
  output logic outputEnableN,
  output logic chipSelectPrimaryN,
  output logic chipSelectSecondary,
  output logic chipSelectTertiaryN,
  output logic processorAddrStrobeN,
  output logic controllerAddrStrobeN,
  output logic burstStepN,
  output logic globalWriteN,
  output logic byteWriteGateN,
  output logic [3:0] laneWriteN,
  output logic burstOrderSelectN,
  output logic [5:0] addrIn,
  output logic [35:0] dqIn
);
  // ***********************************************
  // idle bus: strobes high, deselected
  // ***********************************************
  initial begin
    sleepRequest = 1'b0;
    outputEnableN = 1'b1;
    {chipSelectPrimaryN, chipSelectSecondary, chipSelectTertiaryN} = 3'h6;
    {processorAddrStrobeN, controllerAddrStrobeN, burstStepN} = 3'h7;
    {globalWriteN, byteWriteGateN, laneWriteN} = 6'h3F;
    burstOrderSelectN = 1'b0;
    addrIn = 6'h00;
    dqIn = 36'h000000000;
  end
  // called after a falling edge, returns on the sampling rising edge
  task automatic cyc(input logic [2:0] sel, input logic [4:0] c, input logic [3:0] ln,
    input logic [5:0] a, input logic [35:0] d, input logic oe);
    {chipSelectPrimaryN, chipSelectSecondary, chipSelectTertiaryN} = sel;
    {processorAddrStrobeN, controllerAddrStrobeN, burstStepN} = c[4:2];
    {globalWriteN, byteWriteGateN, laneWriteN} = {c[1:0], ln};
    addrIn = a;
    dqIn = d;
    // outputs off on any write so the bus is never fought over
    outputEnableN = oe | !c[1] | (!c[0] & ~&ln);
    @(posedge clk_sys);
  endtask : cyc
  task automatic doze(input int n);
    // raised off the sampling edge, never in the edge's own time step
    @(negedge clk_sys);
    sleepRequest = 1'b1;
    outputEnableN = 1'b0;
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
    sleepRequest = 1'b0;
    // the three edges the wake-up takes, sleep-exit edge included
    repeat (3) @(posedge clk_sys);
  endtask : doze
endmodule : sbsc_master_model

// file: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import sbsc_pkg::*;
  logic clk_sys, rstn, sleepRequest, outputEnableN, chipSelectPrimaryN, chipSelectSecondary;
  logic chipSelectTertiaryN, processorAddrStrobeN, controllerAddrStrobeN, burstStepN;
  logic globalWriteN, byteWriteGateN, burstOrderSelectN, dqOeN;
  logic [3:0] laneWriteN;
  logic [5:0] addrIn, bA;
  logic [35:0] dqIn, dqOut, d1, d2;
  logic [35:0] mem [64];
  logic [1:0] bK;
  logic v1, v2, pOe, act;
  sbsc_state_e powerState;
  sbsc_op_e lastOp, pOp;
  int fail_count, n_tests;
  sbsc_access_ctrl #(.ADDR_W(6)) dut (.clk_sys, .rstn, .sleepRequest, .outputEnableN,
    .chipSelectPrimaryN, .chipSelectSecondary, .chipSelectTertiaryN, .processorAddrStrobeN,
    .controllerAddrStrobeN, .burstStepN, .globalWriteN, .byteWriteGateN, .laneWriteN,
    .burstOrderSelectN, .addrIn, .dqIn, .dqOut, .dqOeN, .powerState, .lastOp);
  sbsc_master_model m (.clk_sys, .sleepRequest, .outputEnableN, .chipSelectPrimaryN,
    .chipSelectSecondary, .chipSelectTertiaryN, .processorAddrStrobeN,
    .controllerAddrStrobeN, .burstStepN, .globalWriteN, .byteWriteGateN, .laneWriteN,
    .burstOrderSelectN, .addrIn, .dqIn);
  // ***********************************************
  // helpers
  // ***********************************************
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  function automatic logic [35:0] rnd();
    return 36'({$urandom(), $urandom()});
  endfunction : rnd
  // one bus cycle plus the expected outcome of it
  task automatic op(input logic [2:0] sel, input logic [4:0] c, input logic [3:0] ln,
    input logic [5:0] a, input logic [35:0] d, input logic oe);
    logic pN, sec, terN, ps, cs, wr, rd;
    logic [3:0] mk;
    logic [5:0] ad;
    @(negedge clk_sys);
    if (v2) chk("dqOut", d2, dqOut);
    if (v2 && !pOe) chk("dqOeN low", 36'h0, dqOeN);
    if (pOe || !v2) chk("dqOeN high", 36'h1, dqOeN);
    chk("lastOp", pOp, lastOp);
    v2 = v1;
    d2 = d1;
    m.cyc(sel, c, ln, a, d, oe);
    pOe = outputEnableN;
    {pN, sec, terN} = sel;
    {ps, cs} = c[4:3];
    wr = !c[1] | (!c[0] & ~&ln);
    mk = !c[1] ? 4'hF : (!c[0] ? ~ln : 4'h0);
    rd = 1'b0;
    if ((pN & !cs) | (!pN & (!sec | terN) & (!ps | !cs))) begin
      act = 1'b0;
      wr = 1'b0;
      pOp = OP_DESEL;
    end else if (!pN & (!ps | !cs)) begin
      if (!ps) wr = 1'b0;
      bA = a;
      bK = 2'h0;
      act = 1'b1;
      rd = !wr;
      pOp = OP_BEGIN;
    end else if (act) begin
      if (!c[2]) bK = bK + 2'h1;
      rd = !wr;
      pOp = c[2] ? OP_SUSP : OP_CONT;
    end else begin
      wr = 1'b0;
      pOp = OP_IDLE;
    end
    ad = {bA[5:2], burstOrderSelectN ? bA[1:0] ^ bK : bA[1:0] + bK};
    if (wr) for (int i = 0; i < 4; i++) if (mk[i]) mem[ad][i*9+:9] = d[i*9+:9];
    v1 = rd;
    d1 = mem[ad];
  endtask : op
  // ***********************************************
  // sequence
  // ***********************************************
  initial begin
    #200000;
    fail_count++;
    results();
  end
  initial begin
    rstn = 1'b0;
    fail_count = 0;
    n_tests = 0;
    {v1, v2, pOe, act} = 4'h2;
    pOp = OP_IDLE;
    bA = 6'h00;
    bK = 2'h0;
    void'($urandom(63));
    repeat (16) @(negedge clk_sys);
    chk("rst dqOeN", 36'h1, dqOeN);
    chk("rst dqOut", 36'h0, dqOut);
    chk("rst lastOp", OP_IDLE, lastOp);
    chk("rst state", ST_RUN, powerState);
    rstn = 1'b1;
    for (int i = 0; i < 64; i++) op(3'h2, 5'h15, 4'hF, 6'(i), rnd(), 1'b1);
    for (int i = 0; i < 16; i++) begin
      op(3'h2, 5'h16, 4'(i), 6'h15, rnd(), 1'b1);
      op(3'h2, 5'h0F, 4'h0, 6'h15, rnd(), 1'b0);
    end
    op(3'h2, 5'h0D, 4'h0, 6'h16, rnd(), 1'b0);
    for (int o = 0; o < 2; o++) begin
      m.burstOrderSelectN <= 1'(o);
      op(3'h2, 5'h0F, 4'h0, 6'h26, rnd(), 1'b0);
      repeat (5) op(3'h2, 5'h1B, 4'hF, 6'h00, rnd(), 1'b0);
      op(3'h2, 5'h1F, 4'hF, 6'h00, rnd(), 1'b0);
      op(3'h2, 5'h1E, 4'hA, 6'h00, rnd(), 1'b1);
      op(3'h2, 5'h1F, 4'hF, 6'h00, rnd(), 1'b0);
    end
    op(3'h6, 5'h17, 4'hF, 6'h01, rnd(), 1'b0);
    op(3'h2, 5'h1B, 4'hF, 6'h01, rnd(), 1'b0);
    op(3'h0, 5'h0F, 4'hF, 6'h01, rnd(), 1'b0);
    op(3'h3, 5'h17, 4'hF, 6'h01, rnd(), 1'b0);
    op(3'h6, 5'h1F, 4'hF, 6'h01, rnd(), 1'b0);
    // read just before sleep: only the sleep gate can keep the pins off
    op(3'h2, 5'h0F, 4'hF, 6'h01, rnd(), 1'b0);
    fork
      m.doze(4);
      begin
        repeat (2) @(negedge clk_sys);
        chk("sleep dqOeN", 36'h1, dqOeN);
        @(negedge clk_sys);
        chk("sleep state", ST_SLEEP, powerState);
      end
    join
    // burst state survives sleep, so act is kept
    {v1, pOe} = 2'h0;
    pOp = OP_IDLE;
    for (int i = 0; i < 400; i++) begin
      if (i == 200) op(3'h6, 5'h17, 4'hF, 6'h00, rnd(), 1'b1);
      if (i == 200) m.burstOrderSelectN <= 1'b1;
      op(($urandom() % 4 == 0) ? 3'($urandom()) : 3'h2, 5'($urandom()), 4'($urandom()),
        6'($urandom()), rnd(), 1'($urandom()));
    end
    op(3'h6, 5'h1F, 4'hF, 6'h00, rnd(), 1'b0);
    op(3'h6, 5'h1F, 4'hF, 6'h00, rnd(), 1'b0);
    results();
  end
endmodule : tb_top
